// ### mafvt_map.svh
`ifndef MAFVT_MAP_SVH
`define MAFVT_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MAFVT_STATION_ADDR_LOW   18'h00700
`define MAFVT_STATION_ADDR_HIGH  18'h00704
`define MAFVT_FILTER_SELECT      18'h00708
`define MAFVT_FILTER_ADDR_LOW    18'h00710
`define MAFVT_FILTER_ADDR_HIGH   18'h00714
`define MAFVT_TX_VLAN_BASE       18'h04000
`define MAFVT_RX_VLAN_BASE       18'h08000
`define MAFVT_VLAN_SPAN_TOP      4'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MAFVT_ACCEPT_ALL_BIT     31
`define MAFVT_SLOT_MSB           7
`define MAFVT_VLAN_XLATE_MSB     11
`define MAFVT_VLAN_STRIP_BIT     12
`define MAFVT_VLAN_TAG_BIT       13
`define MAFVT_FILTER_COUNT       4
`define MAFVT_VLAN_DEPTH         4096
`define MAFVT_VLAN_WIDTH         14

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MAFVT_SOFT_ADDR_LOW_RST  32'hffffffff
`define MAFVT_SOFT_ADDR_HIGH_RST 16'hffff
`define MAFVT_HARD_ADDR_LOW_RST  32'hddccbbaa
`define MAFVT_HARD_ADDR_HIGH_RST 16'hffee
`define MAFVT_FILT_LOW_RST       32'hffffffff
`define MAFVT_FILT_HIGH_RST      16'hffff
`define MAFVT_SLOT_RST           8'h00

`endif

// ### mafvt_pkg.sv
package mafvt_pkg;

    typedef logic [47:0] mafvt_mac_t;
    typedef logic [13:0] mafvt_vlan_t;

    typedef enum logic [2:0] {
        MAFVT_IDLE  = 3'b001,
        MAFVT_CHECK = 3'b010,
        MAFVT_DONE  = 3'b100
    } mafvt_state_t;

endpackage : mafvt_pkg

// ### mafvt_vlan_table.sv
`timescale 1ns/1ps
`include "mafvt_map.svh"

module mafvt_vlan_table
    import mafvt_pkg::*;
#(
    parameter bit HAS_XLATE = 1'b1,
    parameter bit HAS_STRIP = 1'b1,
    parameter bit HAS_TAG   = 1'b1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // register port side
    input  wire logic        wr_en,
    input  wire logic [11:0] wr_index,
    input  wire logic [13:0] wr_data,
    input  wire logic [11:0] rd_index,
    output logic      [13:0] rd_data,
    // frame side lookup
    input  wire logic [11:0] look_index,
    output logic      [13:0] look_data
);

    // ----------------------------------------------------------------
    // present-field mask, fixed positions
    // ----------------------------------------------------------------
    wire  [13:0] keep_mask = {HAS_TAG, HAS_STRIP, {12{HAS_XLATE}}};
    mafvt_vlan_t store [`MAFVT_VLAN_DEPTH];

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            store[wr_index] <= wr_data & keep_mask;
        end
    end

    assign rd_data   = store[rd_index] & keep_mask;
    assign look_data = store[look_index] & keep_mask;

endmodule : mafvt_vlan_table

// ### mafvt_addr_match.sv
`timescale 1ns/1ps
`include "mafvt_map.svh"

module mafvt_addr_match
    import mafvt_pkg::*;
(
    // inputs
    input  wire logic [47:0]  dest,
    input  wire logic [47:0]  station,
    input  wire logic [191:0] filters,
    input  wire logic         accept_all,
    // result
    output logic              accept
);

    logic [`MAFVT_FILTER_COUNT-1:0] hit;

    // ----------------------------------------------------------------
    // per-entry compare, any address type
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `MAFVT_FILTER_COUNT; g++) begin : g_cmp
            assign hit[g] = (filters[g*48 +: 48] == dest);
        end
    endgenerate

    assign accept = accept_all || (station == dest) || (|hit);

endmodule : mafvt_addr_match

// ### mafvt_top.sv
// Notes on behaviour
// - station address is low word bits 31:0 plus upper word bits 15:0.
// - station address compared against every received destination address.
// - lowest byte lane holds first byte sent or received on line.
// - station address resets to all ones, or hardened build values.
// - upper bits 31:16 of high address registers read zero, writes ignored.
// - accept-all bit 31 disables filtering; resets to zero.
// - slot index bits 7:0 select filter entry 0 to 3, hold, reset zero.
// - filter address accesses go to the entry the slot index selects.
// - filter low resets all ones, filter high low half resets 0xffff.
// - filter entries match unicast, multicast and broadcast destinations.
// - separate transmit and receive vlan tables, 4K entries each.
// - vlan entry: 12-bit translation, strip bit, tag bit, 14 bits.
// - absent vlan fields ignore writes and read zero.
// - vlan fields keep fixed positions in every build.
// - one vlan entry per 32-bit word; software initialises tables.
// - transmit table serves outgoing frames, receive table incoming frames.
// - exactly four filter entries of six bytes each.
`timescale 1ns/1ps
`include "mafvt_map.svh"

module mafvt_top
    import mafvt_pkg::*;
#(
    parameter bit HARDENED  = 1'b0,
    parameter bit HAS_XLATE = 1'b1,
    parameter bit HAS_STRIP = 1'b1,
    parameter bit HAS_TAG   = 1'b1
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    // register port
    input  wire logic [17:0] REG_ADDR,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [31:0] REG_WDATA,
    output logic      [31:0] REG_RDATA,
    output logic             REG_RVALID,
    // receive destination check
    input  wire logic        RX_DEST_BYTE_VALID,
    input  wire logic        RX_DEST_START,
    input  wire logic [7:0]  RX_DEST_BYTE,
    output logic             RX_FRAME_ACCEPT,
    output logic             RX_FRAME_DROP,
    // vlan lookups
    input  wire logic [11:0] TX_VLAN_ID,
    output logic      [13:0] TX_VLAN_ENTRY,
    input  wire logic [11:0] RX_VLAN_ID,
    output logic      [13:0] RX_VLAN_ENTRY
);

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic is_vlan(input logic [17:0] a, input logic [17:0] base);
        is_vlan = (a[17:14] == base[17:14]) && (a[1:0] == 2'b00);
    endfunction : is_vlan

    localparam logic [31:0] ADDR_LOW_RST  = HARDENED ? `MAFVT_HARD_ADDR_LOW_RST
                                                     : `MAFVT_SOFT_ADDR_LOW_RST;
    localparam logic [15:0] ADDR_HIGH_RST = HARDENED ? `MAFVT_HARD_ADDR_HIGH_RST
                                                     : `MAFVT_SOFT_ADDR_HIGH_RST;

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [31:0]  station_lo;
    logic [15:0]  station_hi;
    logic         accept_all_dest;
    logic [7:0]   filter_slot_index;
    logic [31:0]  filt_lo [`MAFVT_FILTER_COUNT];
    logic [15:0]  filt_hi [`MAFVT_FILTER_COUNT];
    mafvt_mac_t   station_address;
    logic [191:0] filter_flat;

    assign station_address = {station_hi, station_lo};

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire       sel_sa_lo = (REG_ADDR == `MAFVT_STATION_ADDR_LOW);
    wire       sel_sa_hi = (REG_ADDR == `MAFVT_STATION_ADDR_HIGH);
    wire       sel_fsel  = (REG_ADDR == `MAFVT_FILTER_SELECT);
    wire       sel_fa_lo = (REG_ADDR == `MAFVT_FILTER_ADDR_LOW);
    wire       sel_fa_hi = (REG_ADDR == `MAFVT_FILTER_ADDR_HIGH);
    wire       sel_txv   = is_vlan(REG_ADDR, `MAFVT_TX_VLAN_BASE);
    wire       sel_rxv   = is_vlan(REG_ADDR, `MAFVT_RX_VLAN_BASE);
    wire [1:0] slot      = filter_slot_index[1:0];
    wire       slot_ok   = (filter_slot_index < 8'(`MAFVT_FILTER_COUNT));
    wire       wr_go     = CE && REG_WR;
    wire [11:0] vlan_idx = REG_ADDR[13:2];

    // ----------------------------------------------------------------
    // station address and select registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            station_lo        <= ADDR_LOW_RST;
            station_hi        <= ADDR_HIGH_RST;
            accept_all_dest   <= 1'b0;
            filter_slot_index <= `MAFVT_SLOT_RST;
        end else if (wr_go) begin
            if (sel_sa_lo) begin
                station_lo <= REG_WDATA;
            end
            if (sel_sa_hi) begin
                station_hi <= REG_WDATA[15:0];
            end
            if (sel_fsel) begin
                accept_all_dest   <= REG_WDATA[`MAFVT_ACCEPT_ALL_BIT];
                filter_slot_index <= REG_WDATA[`MAFVT_SLOT_MSB:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // filter entries
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `MAFVT_FILTER_COUNT; g++) begin : g_filt
            wire hit_slot = slot_ok && (slot == 2'(g));
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    filt_lo[g] <= `MAFVT_FILT_LOW_RST;
                    filt_hi[g] <= `MAFVT_FILT_HIGH_RST;
                end else if (wr_go && hit_slot) begin
                    if (sel_fa_lo) begin
                        filt_lo[g] <= REG_WDATA;
                    end
                    if (sel_fa_hi) begin
                        filt_hi[g] <= REG_WDATA[15:0];
                    end
                end
            end
            assign filter_flat[g*48 +: 48] = {filt_hi[g], filt_lo[g]};
        end
    endgenerate

    // ----------------------------------------------------------------
    // vlan tables
    // ----------------------------------------------------------------
    logic [13:0] tx_rd;
    logic [13:0] rx_rd;
    logic [13:0] tx_look;
    logic [13:0] rx_look;

    mafvt_vlan_table #(
        .HAS_XLATE (HAS_XLATE),
        .HAS_STRIP (HAS_STRIP),
        .HAS_TAG   (HAS_TAG)
    ) u_tx_vlan (
        .clk        (CLK),
        .resetn     (RESETN),
        .ce         (CE),
        .wr_en      (REG_WR && sel_txv),
        .wr_index   (vlan_idx),
        .wr_data    (REG_WDATA[13:0]),
        .rd_index   (vlan_idx),
        .rd_data    (tx_rd),
        .look_index (TX_VLAN_ID),
        .look_data  (tx_look)
    );

    mafvt_vlan_table #(
        .HAS_XLATE (HAS_XLATE),
        .HAS_STRIP (HAS_STRIP),
        .HAS_TAG   (HAS_TAG)
    ) u_rx_vlan (
        .clk        (CLK),
        .resetn     (RESETN),
        .ce         (CE),
        .wr_en      (REG_WR && sel_rxv),
        .wr_index   (vlan_idx),
        .wr_data    (REG_WDATA[13:0]),
        .rd_index   (vlan_idx),
        .rd_data    (rx_rd),
        .look_index (RX_VLAN_ID),
        .look_data  (rx_look)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        if (sel_sa_lo) begin
            rd_mux = station_lo;
        end else if (sel_sa_hi) begin
            rd_mux = {16'h0000, station_hi};
        end else if (sel_fsel) begin
            rd_mux = {accept_all_dest, 23'h000000, filter_slot_index};
        end else if (sel_fa_lo) begin
            rd_mux = slot_ok ? filt_lo[slot] : 32'h00000000;
        end else if (sel_fa_hi) begin
            rd_mux = slot_ok ? {16'h0000, filt_hi[slot]} : 32'h00000000;
        end else if (sel_txv) begin
            rd_mux = {18'h00000, tx_rd};
        end else if (sel_rxv) begin
            rd_mux = {18'h00000, rx_rd};
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA  <= 32'h00000000;
            REG_RVALID <= 1'b0;
        end else if (CE) begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // destination address capture, first byte in lane 0
    // ----------------------------------------------------------------
    mafvt_state_t state;
    mafvt_state_t next_state;
    logic [47:0]  dest_sr;
    logic [2:0]   byte_cnt;
    logic         verdict;

    always_comb begin
        next_state = state;
        case (state)
            MAFVT_IDLE: begin
                if (RX_DEST_BYTE_VALID && RX_DEST_START) begin
                    next_state = MAFVT_CHECK;
                end
            end
            MAFVT_CHECK: begin
                if (RX_DEST_BYTE_VALID && byte_cnt == 3'h5) begin
                    next_state = MAFVT_DONE;
                end
            end
            MAFVT_DONE: begin
                next_state = MAFVT_IDLE;
            end
            default: begin
                next_state = MAFVT_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state    <= MAFVT_IDLE;
            dest_sr  <= 48'h000000000000;
            byte_cnt <= 3'h0;
        end else if (CE) begin
            state <= next_state;
            if (RX_DEST_BYTE_VALID && RX_DEST_START && state == MAFVT_IDLE) begin
                dest_sr[7:0] <= RX_DEST_BYTE;
                byte_cnt     <= 3'h1;
            end else if (RX_DEST_BYTE_VALID && state == MAFVT_CHECK) begin
                dest_sr[byte_cnt*8 +: 8] <= RX_DEST_BYTE;
                byte_cnt                 <= byte_cnt + 3'h1;
            end
        end
    end

    mafvt_addr_match u_match (
        .dest       (dest_sr),
        .station    (station_address),
        .filters    (filter_flat),
        .accept_all (accept_all_dest),
        .accept     (verdict)
    );

    // ----------------------------------------------------------------
    // verdict and vlan lookup outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RX_FRAME_ACCEPT <= 1'b0;
            RX_FRAME_DROP   <= 1'b0;
            TX_VLAN_ENTRY   <= 14'h0000;
            RX_VLAN_ENTRY   <= 14'h0000;
        end else if (CE) begin
            RX_FRAME_ACCEPT <= (state == MAFVT_DONE) && verdict;
            RX_FRAME_DROP   <= (state == MAFVT_DONE) && !verdict;
            TX_VLAN_ENTRY   <= tx_look;
            RX_VLAN_ENTRY   <= rx_look;
        end
    end

endmodule : mafvt_top

// ### mafvt_monitor.sv
`timescale 1ns/1ps

module mafvt_monitor (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        CE,
    // register port
    input wire logic [17:0] REG_ADDR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        REG_RVALID,
    // receive check
    input wire logic        RX_DEST_BYTE_VALID,
    input wire logic        RX_FRAME_ACCEPT,
    input wire logic        RX_FRAME_DROP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    read_answer_a: assert property (REG_RD && CE |=> REG_RVALID)
        else $error("read not answered after one cycle");
    answer_cause_a: assert property ($rose(REG_RVALID) |-> $past(REG_RD))
        else $error("read answer without request");
    high_reserved_a: assert property (REG_RD && CE && (REG_ADDR == 18'h00704 || REG_ADDR == 18'h00714)
        |=> REG_RDATA[31:16] == 16'h0000) else $error("upper half not zero");
    select_reserved_a: assert property (REG_RD && CE && REG_ADDR == 18'h00708
        |=> REG_RDATA[30:8] == 23'h000000) else $error("select reserved bits not zero");
    vlan_width_a: assert property (REG_RD && CE && REG_ADDR[15:14] != 2'h0
        |=> REG_RDATA[31:14] == 18'h00000) else $error("vlan entry wider than 14 bits");
    verdict_excl_a: assert property (!(RX_FRAME_ACCEPT && RX_FRAME_DROP))
        else $error("accept and drop together");
    verdict_pulse_a: assert property (RX_FRAME_ACCEPT || RX_FRAME_DROP
        |=> !RX_FRAME_ACCEPT && !RX_FRAME_DROP) else $error("verdict longer than one cycle");
    verdict_cause_a: assert property (RX_FRAME_ACCEPT || RX_FRAME_DROP
        |-> $past(RX_DEST_BYTE_VALID, 2)) else $error("verdict not two cycles after last byte");
endmodule : mafvt_monitor

bind mafvt_top mafvt_monitor mon_u (.*);

// ### mafvt_host.sv
`timescale 1ns/1ps

module mafvt_host (
    // clock
    input wire logic        CLK,
    // register port
    output logic     [17:0] REG_ADDR,
    output logic            REG_WR,
    output logic            REG_RD,
    output logic     [31:0] REG_WDATA,
    input wire logic [31:0] REG_RDATA,
    input wire logic        REG_RVALID
);
    initial begin
        REG_ADDR  = 18'h00000;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = 32'h00000000;
    end

    task automatic write_reg(input logic [17:0] a, input logic [31:0] d);
        @(posedge CLK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'b1;
        @(posedge CLK);
        REG_WR    <= 1'b0;
        REG_ADDR  <= ~a;
        REG_WDATA <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [17:0] a, output logic [31:0] d, output logic v);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD   <= 1'b1;
        @(posedge CLK);
        REG_RD   <= 1'b0;
        REG_ADDR <= ~a;
        #1;
        d = REG_RDATA;
        v = REG_RVALID;
    endtask : read_reg

    // every entry of both tables cleared before use
    task automatic init_tables();
        for (int i = 0; i < 4096; i++) begin
            write_reg(18'h04000 + 18'(i * 4), 32'h00000000);
            write_reg(18'h08000 + 18'(i * 4), 32'h00000000);
        end
    endtask : init_tables
endmodule : mafvt_host

// ### tb_mac_address_filter_vlan_tables.sv
`timescale 1ns/1ps

module tb_mac_address_filter_vlan_tables;
    import mafvt_pkg::*;
    logic        CLK = 1'b0, RESETN = 1'b0, CE = 1'b1;
    logic [17:0] REG_ADDR;
    logic        REG_WR, REG_RD, REG_RVALID, RX_FRAME_ACCEPT, RX_FRAME_DROP;
    logic [31:0] REG_WDATA, REG_RDATA;
    logic        RX_DEST_BYTE_VALID = 1'b0, RX_DEST_START = 1'b0;
    logic [7:0]  RX_DEST_BYTE = 8'h00;
    logic [11:0] TX_VLAN_ID = 12'h000, RX_VLAN_ID = 12'h000;
    logic [13:0] TX_VLAN_ENTRY, RX_VLAN_ENTRY;
    int          err_total = 0, n_tests = 0;

    always #12.5 CLK = ~CLK;

    mafvt_top dut_u (.CLK(CLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .RX_DEST_BYTE_VALID(RX_DEST_BYTE_VALID), .RX_DEST_START(RX_DEST_START),
        .RX_DEST_BYTE(RX_DEST_BYTE), .RX_FRAME_ACCEPT(RX_FRAME_ACCEPT), .RX_FRAME_DROP(RX_FRAME_DROP),
        .TX_VLAN_ID(TX_VLAN_ID), .TX_VLAN_ENTRY(TX_VLAN_ENTRY), .RX_VLAN_ID(RX_VLAN_ID),
        .RX_VLAN_ENTRY(RX_VLAN_ENTRY));
    mafvt_host host_u (.CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_check(input logic [17:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        host_u.read_reg(a, d, v);
        check({47'h0, v}, 48'h1);
        check({16'h0, d}, {16'h0, exp});
    endtask : rd_check

    task automatic send_dest(input logic [47:0] a, input logic acc);
        for (int k = 0; k < 6; k++) begin
            @(posedge CLK);
            RX_DEST_BYTE_VALID <= 1'b1;
            RX_DEST_START      <= (k == 0);
            RX_DEST_BYTE       <= a[8*k+:8];
        end
        @(posedge CLK);
        RX_DEST_BYTE_VALID <= 1'b0;
        RX_DEST_BYTE       <= ~a[47:40];
        @(posedge CLK);
        #1;
        check({46'h0, RX_FRAME_ACCEPT, RX_FRAME_DROP}, {46'h0, acc, ~acc});
    endtask : send_dest

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_check(18'h00700, 32'hffffffff);
        rd_check(18'h00704, 32'h0000ffff);
        rd_check(18'h00708, 32'h00000000);
        rd_check(18'h00710, 32'hffffffff);
        rd_check(18'h00714, 32'h0000ffff);
        $display("reset values done");
    endtask : t_reset

    task automatic t_station();
        host_u.write_reg(18'h00700, 32'h44332211);
        host_u.write_reg(18'h00704, 32'hffff6655);
        rd_check(18'h00704, 32'h00006655);
        send_dest(48'h665544332211, 1'b1);
        send_dest(48'h675544332211, 1'b0);
        $display("station address done");
    endtask : t_station

    task automatic t_filters();
        for (int i = 0; i < 4; i++) begin
            host_u.write_reg(18'h00708, 32'(i));
            host_u.write_reg(18'h00710, {24'h0b0c0d, 8'(i)});
            host_u.write_reg(18'h00714, 32'hffff0a01);
        end
        for (int i = 3; i >= 0; i--) begin
            host_u.write_reg(18'h00708, 32'(i));
            rd_check(18'h00710, {24'h0b0c0d, 8'(i)});
            rd_check(18'h00714, 32'h00000a01);
        end
        send_dest(48'h0a010b0c0d03, 1'b1);
        send_dest(48'hffffffffffff, 1'b0);
        host_u.write_reg(18'h00708, 32'h00000004);
        rd_check(18'h00710, 32'h00000000);
        rd_check(18'h00708, 32'h00000004);
        $display("address filters done");
    endtask : t_filters

    task automatic t_accept_all();
        @(posedge CLK);
        CE <= 1'b0;
        host_u.write_reg(18'h00708, 32'h80000000);
        @(posedge CLK);
        CE <= 1'b1;
        rd_check(18'h00708, 32'h00000004);
        host_u.write_reg(18'h00708, 32'h80000000);
        rd_check(18'h00708, 32'h80000000);
        send_dest(48'h123456789abc, 1'b1);
        host_u.write_reg(18'h00708, 32'h00000000);
        send_dest(48'h123456789abc, 1'b0);
        $display("accept all done");
    endtask : t_accept_all

    task automatic t_vlan();
        host_u.init_tables();
        host_u.write_reg(18'h07ffc, 32'hffffffff);
        host_u.write_reg(18'h04014, 32'h00001234);
        host_u.write_reg(18'h08014, 32'h00002555);
        rd_check(18'h07ffc, 32'h00003fff);
        rd_check(18'h0bffc, 32'h00000000);
        rd_check(18'h04014, 32'h00001234);
        rd_check(18'h08014, 32'h00002555);
        @(posedge CLK);
        TX_VLAN_ID <= 12'h005;
        RX_VLAN_ID <= 12'hfff;
        repeat (2) @(posedge CLK);
        #1;
        check({34'h0, TX_VLAN_ENTRY}, 48'h1234);
        check({34'h0, RX_VLAN_ENTRY}, 48'h0000);
        @(posedge CLK);
        RX_VLAN_ID <= 12'h005;
        repeat (2) @(posedge CLK);
        #1;
        check({34'h0, RX_VLAN_ENTRY}, 48'h2555);
        $display("vlan tables done");
    endtask : t_vlan

    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        t_reset();
        t_station();
        t_filters();
        t_accept_all();
        t_vlan();
        complete_run();
    end

    initial begin
        repeat (40000) @(posedge CLK);
        err_total++;
        complete_run();
    end
endmodule : tb_mac_address_filter_vlan_tables
